/* File: urs_defs.svh */
// Register offsets, field positions, reset values and sizes of the register select block
`ifndef URS_DEFS_SVH
`define URS_DEFS_SVH

`define URS_ADDR_W            3
`define URS_DATA_W            8

// Standard set
`define URS_A_HOLD            3'h0
`define URS_A_INT_EN          3'h1
`define URS_A_FIFO            3'h2
`define URS_A_LINE_FMT        3'h3
`define URS_A_MODEM_CTL       3'h4
`define URS_A_LINE_ST         3'h5
`define URS_A_MODEM_ST        3'h6
`define URS_A_SCRATCH         3'h7

// Divisor latches
`define URS_A_DIV_LO          3'h0
`define URS_A_DIV_HI          3'h1

// 650-compatible set
`define URS_A_EFR             3'h2
`define URS_A_XON1            3'h4
`define URS_A_XON2            3'h5
`define URS_A_XOFF1           3'h6
`define URS_A_XOFF2           3'h7

// 950-specific set
`define URS_A_ASR             3'h1
`define URS_A_RFL             3'h3
`define URS_A_TFL             3'h4
`define URS_A_IDX_WIN         3'h5

// Line format control fields
`define URS_LFC_DLAB          7
`define URS_LFC_KEY650        8'hbf

// Extra control fields
`define URS_XC_950_EN         7
`define URS_XC_IDX_RD         6

// Writable bits of the additional status register
`define URS_ASR_WMASK         8'h03

// Indexed control set
`define URS_IDX_DEPTH         8
`define URS_IDX_W             3
`define URS_IDX_XC_SLOT       3'h0

`define URS_RST_BYTE          8'h00

`endif

/* File: urs_pkg.sv */
// Types shared by the register select block
package urs_pkg;

   typedef enum logic [4:0] {
      URS_BANK_STD  = 5'h01,
      URS_BANK_DIV  = 5'h02,
      URS_BANK_650  = 5'h04,
      URS_BANK_950  = 5'h08,
      URS_BANK_IDX  = 5'h10
   } urs_bank_t;

endpackage

/* File: urs_sync2.sv */
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module urs_sync2 #(
   parameter int WIDTH = 1
) (
   input  wire logic             sys_clk,
   input  wire logic             rst_n,
   input  wire logic [WIDTH-1:0] asyncIn,
   output logic      [WIDTH-1:0] syncOut
);

   logic [WIDTH-1:0] stage1_reg;
   logic [WIDTH-1:0] stage1_next;
   logic [WIDTH-1:0] stage2_reg;
   logic [WIDTH-1:0] stage2_next;

   always_comb begin
      stage1_next = asyncIn;
      stage2_next = stage1_reg;
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         stage1_reg <= '0;
         stage2_reg <= '0;
      end else begin
         stage1_reg <= stage1_next;
         stage2_reg <= stage2_next;
      end
   end

   assign syncOut = stage2_reg;

endmodule // urs_sync2

/* File: urs_byte_reg.sv */
// Loadable byte register with reset value
`timescale 1ns/1ps
`include "urs_defs.svh"
module urs_byte_reg #(
   parameter logic [7:0] RESET_VAL = `URS_RST_BYTE
) (
   input  wire logic       sys_clk,
   input  wire logic       rst_n,
   input  wire logic       load,
   input  wire logic [7:0] d,
   output logic      [7:0] q
);

   logic [7:0] value_reg;
   logic [7:0] value_next;

   always_comb begin
      value_next = load ? d : value_reg;
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         value_reg <= RESET_VAL;
      end else begin
         value_reg <= value_next;
      end
   end

   assign q = value_reg;

endmodule // urs_byte_reg

/* File: urs_register_select.sv */
// Host register bus decode and register bank selection for the UART
//
// Operation
// RULE1 - Three address lines pick a register, qualified by line and extra control.
// RULE2 - Divisor-latch bit set: addresses 000 and 001 reach divisor low/high bytes.
// RULE3 - Writing 0xBF to line format control maps in the 650-compatible set.
// RULE4 - That write sets bit 7 and keeps bits 6..0 unchanged.
// RULE5 - Host leaves 650 selection by writing the wanted line format value.
// RULE6 - Extra control bit 7 set makes the 950-specific registers reachable.
// RULE7 - Extra control bit 6 set makes the indexed control set readable; writes to address 101 reach it whenever the 650 set is not selected.
// RULE8 - Standard address 000: write loads transmit byte, read returns received byte.
// RULE9 - After reset all selection bits are zero, standard set everywhere except writes to 101, which reach the indexed set.
`timescale 1ns/1ps
`include "urs_defs.svh"
module urs_register_select (
   input  wire logic       sys_clk,
   input  wire logic       rst_n,
   // Host pins
   input  wire logic [2:0] hostAddr,
   input  wire logic [7:0] hostWrData,
   input  wire logic       hostWr,
   input  wire logic       hostRd,
   output logic      [7:0] hostRdData,
   // UART core status, same clock
   input  wire logic [7:0] rxData,
   input  wire logic [7:0] intIdent,
   input  wire logic [7:0] lineState,
   input  wire logic [7:0] modemState,
   input  wire logic [7:0] rxLevel,
   input  wire logic [7:0] txLevel,
   input  wire logic [7:0] asrStatus,
   // UART core controls
   output logic      [7:0] txData,
   output logic            txLoad,
   output logic            rxPop,
   output logic      [7:0] fifoCtrl,
   output logic            fifoCtrlLoad,
   output logic            lineStateRead,
   output logic            modemStateRead,
   output logic      [7:0] lineFormat,
   output logic            sel650,
   output logic      [7:0] interruptEnable,
   output logic      [7:0] modemControl,
   output logic      [7:0] scratchIndex,
   output logic      [7:0] divisorLow,
   output logic      [7:0] divisorHigh,
   output logic      [7:0] flowCtrl,
   output logic      [7:0] xon1,
   output logic      [7:0] xon2,
   output logic      [7:0] xoff1,
   output logic      [7:0] xoff2,
   output logic      [7:0] extraControl,
   output logic      [1:0] asrCtrl
);

   // Pin synchronisation; address and data ride the same two stages as the strobes
   logic [1:0]  strobeSync;
   logic [10:0] busSync;
   logic [1:0]  strobePrev_reg;
   logic [1:0]  strobePrev_next;
   logic        wrEvt;
   logic        rdEvt;
   logic [2:0]  addr;
   logic [7:0]  wdata;

   urs_sync2 #(.WIDTH(2)) u_strobe_sync (
      .sys_clk (sys_clk),
      .rst_n   (rst_n),
      .asyncIn ({hostWr, hostRd}),
      .syncOut (strobeSync)
   );

   urs_sync2 #(.WIDTH(11)) u_bus_sync (
      .sys_clk (sys_clk),
      .rst_n   (rst_n),
      .asyncIn ({hostAddr, hostWrData}),
      .syncOut (busSync)
   );

   always_comb begin
      strobePrev_next = strobeSync;
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         strobePrev_reg <= 2'h0;
      end else begin
         strobePrev_reg <= strobePrev_next;
      end
   end

   assign wrEvt = strobeSync[1] & ~strobePrev_reg[1];
   assign rdEvt = strobeSync[0] & ~strobePrev_reg[0];
   assign addr  = busSync[10:8];
   assign wdata = busSync[7:0];

   // Line format control and 650 key state
   logic [7:0] lfc_reg;
   logic [7:0] lfc_next;
   logic       key650_reg;
   logic       key650_next;

   // Indexed control set; entry 0 is extra control
   logic [7:0] idx_reg  [0:`URS_IDX_DEPTH-1];
   logic [7:0] idx_next [0:`URS_IDX_DEPTH-1];
   logic [1:0] asr_reg;
   logic [1:0] asr_next;

   logic       dlab;
   logic       en950;
   logic       idxRdEn;

   assign dlab    = lfc_reg[`URS_LFC_DLAB];
   assign en950   = idx_reg[`URS_IDX_XC_SLOT][`URS_XC_950_EN];
   assign idxRdEn = idx_reg[`URS_IDX_XC_SLOT][`URS_XC_IDX_RD];

   // Bank that answers an access; reads and writes differ at the read-only 950 level slots and at the indexed window, which only reads need enabled
   function automatic urs_pkg::urs_bank_t bankSel(
      input logic [2:0] a,
      input logic       isRead,
      input logic       k650,
      input logic       dl,
      input logic       e950,
      input logic       irEn
   );
      urs_pkg::urs_bank_t b;
      b = urs_pkg::URS_BANK_STD;
      if (k650 && (a == `URS_A_EFR || a[2])) begin
         b = urs_pkg::URS_BANK_650; // RULE3
      end else if (dl && (a == `URS_A_DIV_LO || a == `URS_A_DIV_HI)) begin
         b = urs_pkg::URS_BANK_DIV; // RULE2
      end else if (e950 && (a == `URS_A_ASR
                            || (isRead && (a == `URS_A_RFL || a == `URS_A_TFL)))) begin
         b = urs_pkg::URS_BANK_950; // RULE6
      end else if (a == `URS_A_IDX_WIN && (!isRead || irEn)) begin
         // Writes reach the window without the read enable so the read enable itself can be set
         b = urs_pkg::URS_BANK_IDX; // RULE7
      end
      return b;
   endfunction

   urs_pkg::urs_bank_t wrBank;
   urs_pkg::urs_bank_t rdBank;

   assign wrBank = bankSel(addr, 1'b0, key650_reg, dlab, en950, idxRdEn); // RULE1
   assign rdBank = bankSel(addr, 1'b1, key650_reg, dlab, en950, idxRdEn); // RULE1

   logic wrStd;
   logic wrDiv;
   logic wr650;
   logic wrIdx;

   assign wrStd = wrEvt && (wrBank == urs_pkg::URS_BANK_STD);
   assign wrDiv = wrEvt && (wrBank == urs_pkg::URS_BANK_DIV);
   assign wr650 = wrEvt && (wrBank == urs_pkg::URS_BANK_650);
   assign wrIdx = wrEvt && (wrBank == urs_pkg::URS_BANK_IDX);

   always_comb begin
      lfc_next    = lfc_reg;
      key650_next = key650_reg;
      if (wrStd && addr == `URS_A_LINE_FMT) begin
         if (wdata == `URS_LFC_KEY650) begin
            lfc_next    = {1'b1, lfc_reg[6:0]}; // RULE4
            key650_next = 1'b1; // RULE3
         end else begin
            lfc_next    = wdata; // RULE5
            key650_next = 1'b0; // RULE5
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         lfc_reg    <= `URS_RST_BYTE; // RULE9
         key650_reg <= 1'b0; // RULE9
      end else begin
         lfc_reg    <= lfc_next;
         key650_reg <= key650_next;
      end
   end

   always_comb begin
      for (int i = 0; i < `URS_IDX_DEPTH; i++) begin
         idx_next[i] = idx_reg[i];
      end
      asr_next = asr_reg;
      // Indices beyond the set are dropped
      if (wrIdx && scratchIndex < 8'(`URS_IDX_DEPTH)) begin
         idx_next[scratchIndex[`URS_IDX_W-1:0]] = wdata; // RULE7
      end
      if (wrEvt && wrBank == urs_pkg::URS_BANK_950) begin
         asr_next = wdata[1:0] & 2'(`URS_ASR_WMASK); // RULE6
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < `URS_IDX_DEPTH; i++) begin
            idx_reg[i] <= `URS_RST_BYTE; // RULE9
         end
         asr_reg <= 2'h0;
      end else begin
         for (int i = 0; i < `URS_IDX_DEPTH; i++) begin
            idx_reg[i] <= idx_next[i];
         end
         asr_reg <= asr_next;
      end
   end

   // Plain byte registers
   urs_byte_reg u_int_en (.sys_clk(sys_clk), .rst_n(rst_n),
      .load(wrStd && addr == `URS_A_INT_EN), .d(wdata), .q(interruptEnable));
   urs_byte_reg u_modem_ctl (.sys_clk(sys_clk), .rst_n(rst_n),
      .load(wrStd && addr == `URS_A_MODEM_CTL), .d(wdata), .q(modemControl));
   urs_byte_reg u_scratch (.sys_clk(sys_clk), .rst_n(rst_n),
      .load(wrStd && addr == `URS_A_SCRATCH), .d(wdata), .q(scratchIndex));
   urs_byte_reg u_div_lo (.sys_clk(sys_clk), .rst_n(rst_n),
      .load(wrDiv && addr == `URS_A_DIV_LO), .d(wdata), .q(divisorLow)); // RULE2
   urs_byte_reg u_div_hi (.sys_clk(sys_clk), .rst_n(rst_n),
      .load(wrDiv && addr == `URS_A_DIV_HI), .d(wdata), .q(divisorHigh)); // RULE2
   urs_byte_reg u_efr (.sys_clk(sys_clk), .rst_n(rst_n),
      .load(wr650 && addr == `URS_A_EFR), .d(wdata), .q(flowCtrl)); // RULE3
   urs_byte_reg u_xon1 (.sys_clk(sys_clk), .rst_n(rst_n),
      .load(wr650 && addr == `URS_A_XON1), .d(wdata), .q(xon1));
   urs_byte_reg u_xon2 (.sys_clk(sys_clk), .rst_n(rst_n),
      .load(wr650 && addr == `URS_A_XON2), .d(wdata), .q(xon2));
   urs_byte_reg u_xoff1 (.sys_clk(sys_clk), .rst_n(rst_n),
      .load(wr650 && addr == `URS_A_XOFF1), .d(wdata), .q(xoff1));
   urs_byte_reg u_xoff2 (.sys_clk(sys_clk), .rst_n(rst_n),
      .load(wr650 && addr == `URS_A_XOFF2), .d(wdata), .q(xoff2));

   // Read data and one-cycle side effects
   logic [7:0] rdData_reg;
   logic [7:0] rdData_next;
   logic [7:0] txData_reg;
   logic [7:0] txData_next;
   logic [7:0] fifoCtrl_reg;
   logic [7:0] fifoCtrl_next;
   logic [4:0] pulse_reg;
   logic [4:0] pulse_next;

   always_comb begin
      rdData_next   = rdData_reg;
      txData_next   = txData_reg;
      fifoCtrl_next = fifoCtrl_reg;
      pulse_next    = 5'h00;
      if (wrStd && addr == `URS_A_HOLD) begin
         txData_next   = wdata; // RULE8
         pulse_next[0] = 1'b1; // RULE8
      end
      if (wrStd && addr == `URS_A_FIFO) begin
         fifoCtrl_next = wdata;
         pulse_next[1] = 1'b1;
      end
      if (rdEvt) begin
         rdData_next = 8'h00;
         unique case (rdBank)
            urs_pkg::URS_BANK_STD: begin
               unique case (addr)
                  `URS_A_HOLD: begin
                     rdData_next   = rxData; // RULE8
                     pulse_next[2] = 1'b1; // RULE8
                  end
                  `URS_A_INT_EN:    rdData_next = interruptEnable;
                  `URS_A_FIFO:      rdData_next = intIdent;
                  `URS_A_LINE_FMT:  rdData_next = lfc_reg;
                  `URS_A_MODEM_CTL: rdData_next = modemControl;
                  `URS_A_LINE_ST: begin
                     rdData_next   = lineState;
                     pulse_next[3] = 1'b1;
                  end
                  `URS_A_MODEM_ST: begin
                     rdData_next   = modemState;
                     pulse_next[4] = 1'b1;
                  end
                  `URS_A_SCRATCH:   rdData_next = scratchIndex;
               endcase
            end
            urs_pkg::URS_BANK_DIV: begin
               rdData_next = addr[0] ? divisorHigh : divisorLow; // RULE2
            end
            urs_pkg::URS_BANK_650: begin
               unique case (addr)
                  `URS_A_XON1:  rdData_next = xon1;
                  `URS_A_XON2:  rdData_next = xon2;
                  `URS_A_XOFF1: rdData_next = xoff1;
                  `URS_A_XOFF2: rdData_next = xoff2;
                  default:      rdData_next = flowCtrl;
               endcase
            end
            urs_pkg::URS_BANK_950: begin
               unique case (addr)
                  `URS_A_RFL: rdData_next = rxLevel;
                  `URS_A_TFL: rdData_next = txLevel;
                  default:    rdData_next = {asrStatus[7:2], asr_reg};
               endcase
            end
            urs_pkg::URS_BANK_IDX: begin
               if (scratchIndex < 8'(`URS_IDX_DEPTH)) begin
                  rdData_next = idx_reg[scratchIndex[`URS_IDX_W-1:0]]; // RULE7
               end
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rdData_reg   <= 8'h00;
         txData_reg   <= 8'h00;
         fifoCtrl_reg <= 8'h00;
         pulse_reg    <= 5'h00;
      end else begin
         rdData_reg   <= rdData_next;
         txData_reg   <= txData_next;
         fifoCtrl_reg <= fifoCtrl_next;
         pulse_reg    <= pulse_next;
      end
   end

   assign hostRdData     = rdData_reg;
   assign txData         = txData_reg;
   assign txLoad         = pulse_reg[0];
   assign fifoCtrl       = fifoCtrl_reg;
   assign fifoCtrlLoad   = pulse_reg[1];
   assign rxPop          = pulse_reg[2];
   assign lineStateRead  = pulse_reg[3];
   assign modemStateRead = pulse_reg[4];
   assign lineFormat     = lfc_reg;
   assign sel650         = key650_reg;
   assign extraControl   = idx_reg[`URS_IDX_XC_SLOT];
   assign asrCtrl        = asr_reg;

endmodule // urs_register_select

/* File: urs_register_select_checker.sv */
// Port-level assertions for the register select block
`timescale 1ns/1ps
module urs_register_select_checker (
   input wire logic       sys_clk,
   input wire logic       rst_n,
   input wire logic [2:0] hostAddr,
   input wire logic [7:0] hostWrData,
   input wire logic       hostWr,
   input wire logic       hostRd,
   input wire logic [7:0] hostRdData,
   input wire logic [7:0] rxData,
   input wire logic [7:0] lineState,
   input wire logic [7:0] modemState,
   input wire logic [7:0] txData,
   input wire logic       txLoad,
   input wire logic       rxPop,
   input wire logic       lineStateRead,
   input wire logic       modemStateRead,
   input wire logic [7:0] fifoCtrl,
   input wire logic       fifoCtrlLoad,
   input wire logic [7:0] lineFormat,
   input wire logic       sel650,
   input wire logic [7:0] interruptEnable,
   input wire logic [7:0] divisorLow,
   input wire logic [7:0] divisorHigh,
   input wire logic [7:0] extraControl,
   input wire logic [7:0] scratchIndex,
   input wire logic [1:0] asrCtrl
);
   // Mirror of the two-flop pin synchronisers, so decode timing lines up
   logic [2:0]  wrReg, wrNext, rdReg, rdNext;
   logic [5:0]  aReg, aNext;
   logic [15:0] dReg, dNext;
   logic [2:0]  aS;
   logic [7:0]  dS;
   logic        wrE, rdE;

   always_comb begin
      wrNext = {wrReg[1:0], hostWr};
      rdNext = {rdReg[1:0], hostRd};
      aNext  = {aReg[2:0], hostAddr};
      dNext  = {dReg[7:0], hostWrData};
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         wrReg <= '0;
         rdReg <= '0;
         aReg  <= '0;
         dReg  <= '0;
      end else begin
         wrReg <= wrNext;
         rdReg <= rdNext;
         aReg  <= aNext;
         dReg  <= dNext;
      end
   end

   assign aS  = aReg[5:3];
   assign dS  = dReg[15:8];
   assign wrE = wrReg[1] & ~wrReg[2];
   assign rdE = rdReg[1] & ~rdReg[2];

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   sequence holdWr; wrE && aS == 3'h0 && !lineFormat[7]; endsequence
   sequence keyWr;  wrE && aS == 3'h3 && dS == 8'hbf; endsequence
   sequence fmtWr;  wrE && aS == 3'h3 && dS != 8'hbf; endsequence

   tx_load_a: assert property (holdWr |=> txLoad && txData == $past(dS))
      else $error("transmit byte not loaded");
   tx_cause_a: assert property ($rose(txLoad) |-> $past(wrE) && $past(aS) == 3'h0)
      else $error("transmit load without a write");
   div_low_a: assert property (wrE && aS == 3'h0 && lineFormat[7]
      |=> divisorLow == $past(dS) && !txLoad) else $error("divisor low not written");
   div_high_a: assert property (wrE && aS == 3'h1 && lineFormat[7]
      |=> divisorHigh == $past(dS)) else $error("divisor high not written");
   key_650_a: assert property (keyWr |=> sel650
      && lineFormat == ($past(lineFormat) | 8'h80)) else $error("650 entry wrong");
   leave_650_a: assert property (fmtWr |=> !sel650 && lineFormat == $past(dS))
      else $error("line format write wrong");
   rx_read_a: assert property (rdE && aS == 3'h0 && !lineFormat[7]
      |=> rxPop && hostRdData == $past(rxData)) else $error("receive read wrong");
   asr_write_a: assert property (wrE && aS == 3'h1 && !lineFormat[7] && extraControl[7]
      |=> {6'h00, asrCtrl} == ($past(dS) & 8'h03) && $stable(interruptEnable))
      else $error("950 status write wrong");
   index_read_a: assert property (rdE && aS == 3'h5 && !sel650 && extraControl[6]
      && scratchIndex == 8'h00 |=> hostRdData == $past(extraControl))
      else $error("indexed read wrong");
   status_read_a: assert property (rdE && aS == 3'h5 && !sel650 && !extraControl[6]
      |=> lineStateRead && hostRdData == $past(lineState)) else $error("line state read wrong");
   reset_std_a: assert property ($rose(rst_n) |-> lineFormat == 8'h00
      && extraControl == 8'h00 && !sel650) else $error("selection not clear after reset");
   fifo_load_a: assert property (wrE && aS == 3'h2 && !sel650
      |=> fifoCtrlLoad && fifoCtrl == $past(dS))
      else $error("fifo control write wrong");
   modem_read_a: assert property (rdE && aS == 3'h6 && !sel650
      |=> modemStateRead && hostRdData == $past(modemState))
      else $error("modem state read wrong");
endmodule // urs_register_select_checker

/* File: urs_host_model.sv */
// Host processor model driving the register pins
`timescale 1ns/1ps
module urs_host_model (
   input  wire logic       sys_clk,
   input  wire logic [7:0] hostRdData,
   output logic      [2:0] hostAddr,
   output logic      [7:0] hostWrData,
   output logic            hostWr,
   output logic            hostRd
);
   initial begin
      hostAddr   = 3'h0;
      hostWrData = 8'h00;
      hostWr     = 1'b0;
      hostRd     = 1'b0;
   end

   // Pins settle two clocks ahead of the strobe; no ready, so fixed spacing
   task automatic access(input logic isWr, input logic [2:0] a, input logic [7:0] d,
                         output logic [7:0] q);
      @(negedge sys_clk);
      hostAddr   = a;
      hostWrData = d;
      repeat (2) @(negedge sys_clk);
      hostWr = isWr;
      hostRd = !isWr;
      repeat (5) @(negedge sys_clk);
      q = hostRdData;
      hostWr = 1'b0;
      hostRd = 1'b0;
      // Released lines show the inverse so stale values cannot pass
      hostAddr   = ~a;
      hostWrData = ~d;
      repeat (3) @(negedge sys_clk);
   endtask
endmodule // urs_host_model

/* File: urs_register_select_tb.sv */
// Self-checking bench for the register select block
`timescale 1ns/1ps
module urs_register_select_tb;
   logic       sys_clk, rst_n, hostWr, hostRd, txLoad, rxPop, fifoCtrlLoad, sel650;
   logic       lineStateRead, modemStateRead;
   logic [2:0] hostAddr;
   logic [1:0] asrCtrl;
   logic [7:0] hostWrData, hostRdData, rxData, intIdent, lineState, modemState, rxLevel;
   logic [7:0] txLevel, asrStatus, txData, fifoCtrl, lineFormat, interruptEnable;
   logic [7:0] modemControl, scratchIndex, divisorLow, divisorHigh, flowCtrl;
   logic [7:0] xon1, xon2, xoff1, xoff2, extraControl;
   int         failures, tests_run;

   urs_register_select dut (.sys_clk, .rst_n, .hostAddr, .hostWrData, .hostWr, .hostRd,
      .hostRdData, .rxData, .intIdent, .lineState, .modemState, .rxLevel, .txLevel,
      .asrStatus, .txData, .txLoad, .rxPop, .fifoCtrl, .fifoCtrlLoad, .lineStateRead,
      .modemStateRead, .lineFormat, .sel650, .interruptEnable, .modemControl,
      .scratchIndex, .divisorLow, .divisorHigh, .flowCtrl, .xon1, .xon2, .xoff1,
      .xoff2, .extraControl, .asrCtrl);
   urs_host_model host (.sys_clk, .hostRdData, .hostAddr, .hostWrData, .hostWr, .hostRd);

   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         failures++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      logic [7:0] q;
      host.access(1'b1, a, d, q);
   endtask

   task automatic rdc(input string what, input logic [2:0] a, input logic [7:0] exp);
      logic [7:0] q;
      host.access(1'b0, a, 8'h00, q);
      check(what, q, exp);
   endtask

   task automatic setStatus(input logic [7:0] s);
      rxData     = s;
      intIdent   = s ^ 8'h11;
      lineState  = s ^ 8'h22;
      modemState = s ^ 8'h44;
      rxLevel    = s ^ 8'h0f;
      txLevel    = s ^ 8'hf0;
      asrStatus  = s ^ 8'h5a;
   endtask

   task automatic t_reset;
      check("lineFormat", lineFormat, 8'h00);
      check("extraControl", extraControl, 8'h00);
      check("sel650", {7'h00, sel650}, 8'h00);
      rdc("lineFormat", 3'h3, 8'h00);
      $display("test reset done");
   endtask

   task automatic t_std;
      setStatus(8'h3c);
      wr(3'h0, 8'ha5);
      check("txData", txData, 8'ha5);
      rdc("rxHold", 3'h0, rxData);
      wr(3'h1, 8'h5e);
      wr(3'h2, 8'hc7);
      wr(3'h4, 8'h1d);
      wr(3'h7, 8'h06);
      check("intEnable", interruptEnable, 8'h5e);
      check("fifoCtrl", fifoCtrl, 8'hc7);
      check("modemControl", modemControl, 8'h1d);
      rdc("ident", 3'h2, intIdent);
      rdc("lineState", 3'h5, lineState);
      rdc("modemState", 3'h6, modemState);
      rdc("scratch", 3'h7, 8'h06);
      $display("test standard done");
   endtask

   task automatic t_div;
      wr(3'h3, 8'h83);
      wr(3'h0, 8'h12);
      wr(3'h1, 8'h34);
      check("divLo", divisorLow, 8'h12);
      check("divHi", divisorHigh, 8'h34);
      check("txData", txData, 8'ha5);
      check("intEnable", interruptEnable, 8'h5e);
      rdc("divLo", 3'h0, 8'h12);
      rdc("divHi", 3'h1, 8'h34);
      wr(3'h3, 8'h03);
      rdc("rxHold", 3'h0, rxData);
      $display("test divisor done");
   endtask

   task automatic t_650;
      wr(3'h3, 8'h1b);
      wr(3'h3, 8'hbf);
      check("lineFormat", lineFormat, 8'h9b);
      check("sel650", {7'h00, sel650}, 8'h01);
      rdc("lineFormat", 3'h3, 8'h9b);
      for (int i = 2; i < 8; i++) begin
         if (i != 3) begin
            wr(3'(i), 8'h60 + 8'(i));
            rdc("set650", 3'(i), 8'h60 + 8'(i));
         end
      end
      check("efr", flowCtrl, 8'h62);
      check("xon1", xon1, 8'h64);
      check("xon2", xon2, 8'h65);
      check("xoff1", xoff1, 8'h66);
      check("xoff2", xoff2, 8'h67);
      // Host leaves the 650 set by writing the format it wants
      wr(3'h3, 8'h03);
      check("sel650", {7'h00, sel650}, 8'h00);
      check("lineFormat", lineFormat, 8'h03);
      rdc("scratch", 3'h7, 8'h06);
      $display("test 650 set done");
   endtask

   task automatic t_950;
      setStatus(8'h9e);
      wr(3'h7, 8'h00);
      wr(3'h5, 8'h80);
      check("extraControl", extraControl, 8'h80);
      wr(3'h1, 8'hff);
      check("asrCtrl", {6'h00, asrCtrl}, 8'h03);
      check("intEnable", interruptEnable, 8'h5e);
      rdc("asr", 3'h1, {asrStatus[7:2], 2'h3});
      rdc("rfl", 3'h3, rxLevel);
      rdc("tfl", 3'h4, txLevel);
      $display("test 950 set done");
   endtask

   task automatic t_icr;
      wr(3'h5, 8'h40);
      check("extraControl", extraControl, 8'h40);
      rdc("extraControl", 3'h5, 8'h40);
      // Index past the eight entries: write dropped, read empty
      wr(3'h7, 8'h09);
      wr(3'h5, 8'h77);
      rdc("unused", 3'h5, 8'h00);
      wr(3'h7, 8'h00);
      check("extraControl", extraControl, 8'h40);
      wr(3'h5, 8'h00);
      rdc("lineState", 3'h5, lineState);
      $display("test indexed set done");
   endtask

   task automatic end_of_test;
      $display("checks %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end

   initial begin
      failures  = 0;
      tests_run = 0;
      rst_n     = 1'b0;
      setStatus(8'h00);
      repeat (20) @(negedge sys_clk);
      rst_n = 1'b1;
      t_reset();
      t_std();
      t_div();
      t_650();
      t_950();
      t_icr();
      end_of_test();
   end

   initial begin
      repeat (20000) @(posedge sys_clk);
      failures++;
      $display("unexpected run length: expected end seen timeout");
      end_of_test();
   end
endmodule // urs_register_select_tb

bind urs_register_select urs_register_select_checker chk (.sys_clk, .rst_n, .hostAddr,
   .hostWrData, .hostWr, .hostRd, .hostRdData, .rxData, .lineState, .modemState, .txData,
   .txLoad, .rxPop, .lineStateRead, .modemStateRead, .fifoCtrl, .fifoCtrlLoad,
   .lineFormat, .sel650, .interruptEnable, .divisorLow,
   .divisorHigh, .extraControl, .scratchIndex, .asrCtrl);
